// *** rtl/switch_lookup_consts.vh ***
// Purpose: Shared constants of the switch lookup and MAC engine.
// Assumes: 200 MHz core clock, AXI4-Lite word registers.
// Notes: Register indices are word indices; the byte address is four times the index.
`ifndef SWITCH_LOOKUP_CONSTS_VH
`define SWITCH_LOOKUP_CONSTS_VH
`define IDX_CTRL3 6'h03
`define IDX_CTRL4 6'h04
`define IDX_STATUS 6'h08
`define IDX_FWD 6'h09
`define CTRL3_RST 32'h0000_0004
`define CTRL3_MASK 32'h0000_0005
`define CTRL4_RST 32'h0000_0000
`define CTRL4_MASK 32'h0000_0038
`define FWD_RST 32'h0001_FF07
`define FWD_MASK 32'h0001_FFFF
`define B_AGGR 0
`define B_AGE_EN 2
`define B_NODROP 3
`define B_MAXSZ 4
`define LEN_MIN 11'h040
`define LEN_1518 11'h5EE
`define LEN_1536 11'h600
`define LEN_1916 11'h77C
`define LEN_TAG 11'h004
`define IPG_BITS 10'h060
`define SLOT_BITS 10'h200
`define MAX_COLL 5'h10
`define BO_LIMIT 5'h0A
`define BO_AGGR_LIMIT 5'h03
`define CLK_PERIOD_PS 32'h0000_1388
`define BIT_PS_100 32'h0000_2710
`define BIT_PS_10 32'h0001_86A0
`define CLK_HZ 32'h0BEB_C200
`define AGE_TIME_S 8'hC8
`define BUF_SHIFT 7
`define BUF_ROUND 12'h07F
`define BUF_TOTAL 9'h100
`define FC_LOW 9'h020
`define FC_HIGH 9'h040
`define PAUSE_MAX 16'hFFFF
`define HOST_PORT 2'h2
`define LFSR_SEED 16'hACE1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** rtl/switch_lookup_mac_engine.v ***
// Purpose: Address lookup, learning, aging, forwarding and per-port MAC timing of a 3-port switch.
// Assumes: Frame descriptors arrive after the whole frame is received and checked.
// Notes: Table search is a linear scan, so every one of the entries can be learned.
`timescale 1ns/1ps
`include "switch_lookup_consts.vh"

// Notes on behaviour
// - Table holds 1K unicast entries, all learnable, no hash limit.
// - Good frame with unknown source is learned with port and time stamp.
// - Full table: the last entry is replaced by the new one.
// - Known source on another port: record port is overwritten.
// - Known source seen again: its time stamp is refreshed.
// - Records older than about 200 s are removed; ctrl3 bit 2 enables.
// - First-stage mask from VLAN, static, dynamic; refined into final mask.
// - Framing, FCS, alignment and size errors are never forwarded.
// - Pause frames are consumed for flow control, never forwarded.
// - Destination equal to ingress port means local; not forwarded.
// - Store-and-forward pool of 256 buffers of 128 bytes, shared.
// - 96 bit-time gap; after collision measured from carrier sense.
// - Half duplex retries with binary exponential back-off, aggressive option.
// - After 16 collisions drop or keep retrying per ctrl4 bit 3.
// - Collision after 512 bit times drops the frame without retry.
// - Frames under 64 bytes discarded; max 1518, 1536 or 1916 selectable.
// - VLAN tagged frames get the maximum length enlarged by the tag.
// - Received pause holds normal frames until the pause timer expires.
// - A new pause before expiry reloads the timer.
// - While paused only own flow control frames are sent.
// - Busy destination sends pause-on max time; pause-off zero, with hysteresis.
// - Full receive queue flow-controls all ports at once.
// - Aggressive back-off enabled by ctrl3 bit 0, off at reset.
module switch_lookup_mac_engine #(
  parameter TBL_DEPTH = 1024,
  parameter TBL_AW = 10,
  parameter AGE_TICK_CYCLES = 200000000
) (
  input wire CORE_CLK,
  input wire RESET_N,
  input wire CE,
  input wire [7:0] AWADDR,
  input wire AWVALID,
  output wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output wire WREADY,
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  input wire [7:0] ARADDR,
  input wire ARVALID,
  output wire ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  input wire RX_VALID,
  output wire RX_READY,
  input wire [1:0] RX_PORT,
  input wire [47:0] RX_SA,
  input wire [47:0] RX_DA,
  input wire [10:0] RX_LEN,
  input wire RX_ERR,
  input wire RX_TAGGED,
  input wire RX_PAUSE,
  input wire [15:0] RX_PAUSE_TIME,
  input wire [2:0] RX_VLAN_MASK,
  input wire RX_STATIC_HIT,
  input wire [2:0] RX_STATIC_MASK,
  input wire RX_IGMP,
  output reg FWD_VALID,
  output reg [1:0] FWD_PORT,
  output reg [2:0] FWD_MASK,
  input wire BUF_RELEASE,
  input wire [4:0] BUF_RELEASE_CNT,
  input wire [2:0] DEST_BUSY,
  input wire RXQ_FULL,
  output reg [2:0] PAUSE_ON_FRAME,
  output reg [2:0] PAUSE_OFF_FRAME,
  input wire [2:0] SPEED100,
  input wire [2:0] FULL_DUPLEX,
  input wire [2:0] TX_REQ,
  input wire [2:0] TX_FC,
  input wire [2:0] TX_END,
  input wire [2:0] MII_COL,
  input wire [2:0] MII_CARRIER_SENSE,
  output wire [2:0] MII_TRANSMIT_ENABLE,
  output wire [2:0] TX_DONE,
  output wire [2:0] TX_ABORT,
  output wire [2:0] PAUSED
);
  localparam S_IDLE = 3'b001;
  localparam S_SCAN = 3'b010;
  localparam S_DECIDE = 3'b100;
  localparam T_IDLE = 4'b0001;
  localparam T_XMIT = 4'b0010;
  localparam T_BOFF = 4'b0100;
  localparam T_IPG = 4'b1000;
  localparam [31:0] BC100_W = (`BIT_PS_100 / `CLK_PERIOD_PS) - 32'h0000_0001;
  localparam [31:0] BC10_W = (`BIT_PS_10 / `CLK_PERIOD_PS) - 32'h0000_0001;
  localparam [31:0] LAST_W = TBL_DEPTH - 1;
  localparam [4:0] BC100 = BC100_W[4:0];
  localparam [4:0] BC10 = BC10_W[4:0];
  localparam [TBL_AW-1:0] LAST_IDX = LAST_W[TBL_AW-1:0];
  localparam [31:0] AGE_TICK_LAST = AGE_TICK_CYCLES - 1;

  function [2:0] onehot;
    input [1:0] p;
    begin
      case (p)
        2'h0: onehot = 3'b001;
        2'h1: onehot = 3'b010;
        default: onehot = 3'b100;
      endcase
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    input [31:0] m;
    reg [31:0] bm;
    begin
      bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      wmerge = ((old & ~bm) | (d & bm)) & m;
    end
  endfunction

  reg rs1_reg, rst_n;
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rs1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rst_n <= rs1_reg;
    end
  end

  // Register file over AXI4-Lite; address and data are taken in either order.
  reg aw_got_reg, w_got_reg;
  reg [5:0] aw_idx_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg [31:0] ctrl3_reg, ctrl4_reg, fwd_cfg_reg;
  reg [10:0] count_reg;
  reg [8:0] free_reg;
  reg [2:0] pause_on_frame_reg;
  wire [5:0] ar_idx = ARADDR[7:2];
  assign AWREADY = !aw_got_reg && !BVALID;
  assign WREADY = !w_got_reg && !BVALID;
  assign ARREADY = !RVALID;
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= `RESP_OKAY;
      RVALID <= 1'b0;
      RRESP <= `RESP_OKAY;
      RDATA <= 32'h0000_0000;
      ctrl3_reg <= `CTRL3_RST;
      ctrl4_reg <= `CTRL4_RST;
      fwd_cfg_reg <= `FWD_RST;
    end else if (CE) begin
      if (AWVALID && AWREADY) begin
        aw_got_reg <= 1'b1;
        aw_idx_reg <= AWADDR[7:2];
      end
      if (WVALID && WREADY) begin
        w_got_reg <= 1'b1;
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
      end
      if (aw_got_reg && w_got_reg) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= `RESP_OKAY;
        case (aw_idx_reg)
          `IDX_CTRL3: ctrl3_reg <= wmerge(ctrl3_reg, wdata_reg, wstrb_reg, `CTRL3_MASK);
          `IDX_CTRL4: ctrl4_reg <= wmerge(ctrl4_reg, wdata_reg, wstrb_reg, `CTRL4_MASK);
          `IDX_FWD: fwd_cfg_reg <= wmerge(fwd_cfg_reg, wdata_reg, wstrb_reg, `FWD_MASK);
          `IDX_STATUS: BRESP <= `RESP_OKAY;
          default: BRESP <= `RESP_SLVERR;
        endcase
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP <= `RESP_OKAY;
        case (ar_idx)
          `IDX_CTRL3: RDATA <= ctrl3_reg;
          `IDX_CTRL4: RDATA <= ctrl4_reg;
          `IDX_FWD: RDATA <= fwd_cfg_reg;
          `IDX_STATUS: RDATA <= {1'b0, PAUSED, pause_on_frame_reg, free_reg, 5'h00, count_reg};
          default: begin
            RDATA <= 32'h0000_0000;
            RRESP <= `RESP_SLVERR;
          end
        endcase
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  wire aggr = ctrl3_reg[`B_AGGR];
  wire age_en = ctrl3_reg[`B_AGE_EN];
  wire nodrop = ctrl4_reg[`B_NODROP];
  wire [1:0] maxsz = ctrl4_reg[`B_MAXSZ+1:`B_MAXSZ];
  wire [2:0] stp_fwd = fwd_cfg_reg[2:0];
  wire [2:0] mirror_src = fwd_cfg_reg[5:3];
  wire [1:0] mirror_port = fwd_cfg_reg[7:6];

  reg [47:0] tbl_mac [0:TBL_DEPTH-1];
  reg [1:0] tbl_port [0:TBL_DEPTH-1];
  reg [7:0] tbl_stamp [0:TBL_DEPTH-1];
  reg [TBL_DEPTH-1:0] tbl_valid_reg;
  reg [2:0] st_reg;
  reg [TBL_AW-1:0] idx_reg, sa_idx_reg, free_idx_reg, age_ptr_reg;
  reg sa_hit_reg, da_hit_reg, free_found_reg;
  reg [1:0] da_port_reg, src_reg;
  reg [47:0] sa_reg, da_reg;
  reg [10:0] len_reg;
  reg err_reg, tag_reg, pause_reg, static_reg, igmp_reg;
  reg [15:0] ptime_reg;
  reg [2:0] vlan_reg, smask_reg, pause_load_reg;
  reg [31:0] age_div_reg;
  reg [7:0] epoch_reg;
  assign RX_READY = st_reg[0];

  reg [10:0] max_len;
  always @* begin
    case (maxsz)
      2'h1: max_len = `LEN_1536;
      2'h2: max_len = `LEN_1916;
      default: max_len = `LEN_1518;
    endcase
  end
  // Length window, tag enlarges the top.
  wire len_ok = (len_reg >= `LEN_MIN) && (len_reg <= (tag_reg ? max_len + `LEN_TAG : max_len));
  wire good = !err_reg && len_ok;
  wire da_mc = da_reg[40];
  // First stage from VLAN, static and dynamic lookups.
  wire [2:0] first_stage_port_mask =
    (static_reg ? smask_reg : (!da_mc && da_hit_reg) ? onehot(da_port_reg) : 3'b111) & vlan_reg;
  wire local_hit = !static_reg && !da_mc && da_hit_reg && (da_port_reg == src_reg);
  wire [2:0] snoop_mask = igmp_reg ? onehot(`HOST_PORT) : first_stage_port_mask;
  wire [2:0] pvlan = (src_reg == 2'h0) ? fwd_cfg_reg[10:8] :
                     (src_reg == 2'h1) ? fwd_cfg_reg[13:11] : fwd_cfg_reg[16:14];
  wire [2:0] base_mask = snoop_mask & stp_fwd & pvlan & ~onehot(src_reg);
  wire [2:0] mir_mask = (mirror_src & onehot(src_reg)) != 3'b000 ? onehot(mirror_port) & ~onehot(src_reg) : 3'b000;
  wire [11:0] len_round = {1'b0, len_reg} + `BUF_ROUND;
  wire [4:0] nbuf = len_round[11:`BUF_SHIFT];
  wire src_fwd = (stp_fwd & onehot(src_reg)) != 3'b000;
  // Pause frames stop here; a frame needs room in the pool.
  wire [2:0] final_port_mask = (good && !pause_reg && !local_hit && src_fwd && (free_reg >= {4'h0, nbuf}))
                               ? (base_mask | mir_mask) : 3'b000;
  wire deciding = st_reg[2];
  wire alloc = deciding && (final_port_mask != 3'b000);
  wire [7:0] age_diff = epoch_reg - tbl_stamp[age_ptr_reg];

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= S_IDLE;
      idx_reg <= {TBL_AW{1'b0}};
      sa_idx_reg <= {TBL_AW{1'b0}};
      free_idx_reg <= {TBL_AW{1'b0}};
      age_ptr_reg <= {TBL_AW{1'b0}};
      sa_hit_reg <= 1'b0;
      da_hit_reg <= 1'b0;
      free_found_reg <= 1'b0;
      da_port_reg <= 2'h0;
      src_reg <= 2'h0;
      sa_reg <= 48'h0000_0000_0000;
      da_reg <= 48'h0000_0000_0000;
      len_reg <= 11'h000;
      err_reg <= 1'b0;
      tag_reg <= 1'b0;
      pause_reg <= 1'b0;
      static_reg <= 1'b0;
      igmp_reg <= 1'b0;
      ptime_reg <= 16'h0000;
      vlan_reg <= 3'h0;
      smask_reg <= 3'h0;
      pause_load_reg <= 3'h0;
      tbl_valid_reg <= {TBL_DEPTH{1'b0}};
      count_reg <= 11'h000;
      age_div_reg <= 32'h0000_0000;
      epoch_reg <= 8'h00;
      FWD_VALID <= 1'b0;
      FWD_PORT <= 2'h0;
      FWD_MASK <= 3'h0;
    end else if (CE) begin
      FWD_VALID <= 1'b0;
      pause_load_reg <= 3'h0;
      if (age_div_reg == AGE_TICK_LAST) begin
        age_div_reg <= 32'h0000_0000;
        epoch_reg <= epoch_reg + 8'h01;
      end else begin
        age_div_reg <= age_div_reg + 32'h0000_0001;
      end
      case (st_reg)
        S_IDLE: begin
          if (RX_VALID) begin
            st_reg <= S_SCAN;
            idx_reg <= {TBL_AW{1'b0}};
            sa_hit_reg <= 1'b0;
            da_hit_reg <= 1'b0;
            free_found_reg <= 1'b0;
            src_reg <= RX_PORT;
            sa_reg <= RX_SA;
            da_reg <= RX_DA;
            len_reg <= RX_LEN;
            err_reg <= RX_ERR;
            tag_reg <= RX_TAGGED;
            pause_reg <= RX_PAUSE;
            ptime_reg <= RX_PAUSE_TIME;
            vlan_reg <= RX_VLAN_MASK;
            static_reg <= RX_STATIC_HIT;
            smask_reg <= RX_STATIC_MASK;
            igmp_reg <= RX_IGMP;
          end else begin
            // Background aging, one record per idle cycle.
            age_ptr_reg <= age_ptr_reg + 1'b1;
            if (age_en && tbl_valid_reg[age_ptr_reg] && (age_diff >= `AGE_TIME_S)) begin
              tbl_valid_reg[age_ptr_reg] <= 1'b0;
              count_reg <= count_reg - 11'h001;
            end
          end
        end
        S_SCAN: begin
          if (tbl_valid_reg[idx_reg]) begin
            if (tbl_mac[idx_reg] == sa_reg) begin
              sa_hit_reg <= 1'b1;
              sa_idx_reg <= idx_reg;
            end
            if (tbl_mac[idx_reg] == da_reg) begin
              da_hit_reg <= 1'b1;
              da_port_reg <= tbl_port[idx_reg];
            end
          end else if (!free_found_reg) begin
            free_found_reg <= 1'b1;
            free_idx_reg <= idx_reg;
          end
          if (idx_reg == LAST_IDX) begin
            st_reg <= S_DECIDE;
          end
          idx_reg <= idx_reg + 1'b1;
        end
        S_DECIDE: begin
          st_reg <= S_IDLE;
          FWD_VALID <= 1'b1;
          FWD_PORT <= src_reg;
          FWD_MASK <= final_port_mask;
          // Pause value loads or reloads the timer.
          if (good && pause_reg) begin
            pause_load_reg <= onehot(src_reg);
          end
          // Only good frames touch the table.
          if (good && !sa_reg[40]) begin
            if (sa_hit_reg) begin
              tbl_port[sa_idx_reg] <= src_reg;
              tbl_stamp[sa_idx_reg] <= epoch_reg;
            end else if (free_found_reg) begin
              tbl_mac[free_idx_reg] <= sa_reg;
              tbl_port[free_idx_reg] <= src_reg;
              tbl_stamp[free_idx_reg] <= epoch_reg;
              tbl_valid_reg[free_idx_reg] <= 1'b1;
              count_reg <= count_reg + 11'h001;
            end else begin
              // Full table overwrites the last entry.
              tbl_mac[LAST_IDX] <= sa_reg;
              tbl_port[LAST_IDX] <= src_reg;
              tbl_stamp[LAST_IDX] <= epoch_reg;
            end
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // Pause-on has priority; pause-off waits for the higher mark.
  wire [2:0] fc_set = (RXQ_FULL ? 3'b111 : 3'b000) |
    ((alloc && (((DEST_BUSY & final_port_mask) != 3'b000) || (free_reg < `FC_LOW))) ? onehot(src_reg) : 3'b000);
  wire fc_clear = (free_reg >= `FC_HIGH) && (DEST_BUSY == 3'b000) && !RXQ_FULL;
  wire [8:0] rel = BUF_RELEASE ? {4'h0, BUF_RELEASE_CNT} : 9'h000;
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      free_reg <= `BUF_TOTAL;
      pause_on_frame_reg <= 3'h0;
      PAUSE_ON_FRAME <= 3'h0;
      PAUSE_OFF_FRAME <= 3'h0;
    end else if (CE) begin
      free_reg <= free_reg + rel - (alloc ? {4'h0, nbuf} : 9'h000);
      PAUSE_ON_FRAME <= fc_set & ~pause_on_frame_reg;
      PAUSE_OFF_FRAME <= fc_clear ? (pause_on_frame_reg & ~fc_set) : 3'h0;
      pause_on_frame_reg <= fc_set | (fc_clear ? 3'h0 : pause_on_frame_reg);
    end
  end

  // Collision and carrier come from the PHY side and are synchronised first.
  reg [2:0] col_m_reg, col_s_reg, crs_m_reg, crs_s_reg;
  reg [15:0] lfsr_reg;
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      col_m_reg <= 3'h0;
      col_s_reg <= 3'h0;
      crs_m_reg <= 3'h0;
      crs_s_reg <= 3'h0;
      lfsr_reg <= `LFSR_SEED;
    end else if (CE) begin
      col_m_reg <= MII_COL;
      col_s_reg <= col_m_reg;
      crs_m_reg <= MII_CARRIER_SENSE;
      crs_s_reg <= crs_m_reg;
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : port
      reg [3:0] ts_reg;
      reg [4:0] bt_reg, ncol_reg;
      reg [9:0] bits_reg, slots_reg, pbit_reg;
      reg [15:0] pq_reg;
      reg en_reg, done_reg, abort_reg, colflag_reg;
      wire tick = (bt_reg == 5'h00);
      wire col = col_s_reg[g] && !FULL_DUPLEX[g];
      wire [4:0] ncol_next = ncol_reg + 5'h01;
      // Aggressive mode caps the back-off exponent low.
      wire [4:0] lim = aggr ? `BO_AGGR_LIMIT : `BO_LIMIT;
      wire [4:0] k = (ncol_next > lim) ? lim : ncol_next;
      wire [9:0] bo_mask = (10'h001 << k[3:0]) - 10'h001;
      assign MII_TRANSMIT_ENABLE[g] = en_reg;
      assign TX_DONE[g] = done_reg;
      assign TX_ABORT[g] = abort_reg;
      assign PAUSED[g] = (pq_reg != 16'h0000);
      always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
          ts_reg <= T_IDLE;
          bt_reg <= 5'h00;
          ncol_reg <= 5'h00;
          bits_reg <= 10'h000;
          slots_reg <= 10'h000;
          pbit_reg <= 10'h000;
          pq_reg <= 16'h0000;
          en_reg <= 1'b0;
          done_reg <= 1'b0;
          abort_reg <= 1'b0;
          colflag_reg <= 1'b0;
        end else if (CE) begin
          done_reg <= 1'b0;
          abort_reg <= 1'b0;
          bt_reg <= tick ? (SPEED100[g] ? BC100 : BC10) : bt_reg - 5'h01;
          // Quanta of 512 bit times at the present speed.
          if (pause_load_reg[g]) begin
            pq_reg <= ptime_reg;
            pbit_reg <= 10'h000;
          end else if (PAUSED[g] && tick) begin
            pbit_reg <= (pbit_reg == `SLOT_BITS - 10'h001) ? 10'h000 : pbit_reg + 10'h001;
            if (pbit_reg == `SLOT_BITS - 10'h001) begin
              pq_reg <= pq_reg - 16'h0001;
            end
          end
          case (ts_reg)
            T_IDLE: begin
              // Paused ports send flow control frames only.
              if (TX_REQ[g] && (!PAUSED[g] || TX_FC[g])) begin
                ts_reg <= T_XMIT;
                en_reg <= 1'b1;
                bits_reg <= 10'h000;
              end
            end
            T_XMIT: begin
              if (tick && bits_reg != `SLOT_BITS) begin
                bits_reg <= bits_reg + 10'h001;
              end
              if (col) begin
                en_reg <= 1'b0;
                colflag_reg <= 1'b1;
                ts_reg <= T_IPG;
                bits_reg <= 10'h000;
                if (bits_reg == `SLOT_BITS) begin
                  abort_reg <= 1'b1;
                  ncol_reg <= 5'h00;
                end else if (ncol_next == `MAX_COLL) begin
                  // Sixteenth collision: drop unless retry is set.
                  abort_reg <= !nodrop;
                  ncol_reg <= 5'h00;
                end else begin
                  ncol_reg <= ncol_next;
                  slots_reg <= lfsr_reg[9:0] & bo_mask;
                  ts_reg <= T_BOFF;
                end
              end else if (TX_END[g]) begin
                en_reg <= 1'b0;
                done_reg <= 1'b1;
                ncol_reg <= 5'h00;
                colflag_reg <= 1'b0;
                bits_reg <= 10'h000;
                ts_reg <= T_IPG;
              end
            end
            T_BOFF: begin
              if (slots_reg == 10'h000) begin
                ts_reg <= T_IPG;
                bits_reg <= 10'h000;
              end else if (tick) begin
                bits_reg <= (bits_reg == `SLOT_BITS - 10'h001) ? 10'h000 : bits_reg + 10'h001;
                if (bits_reg == `SLOT_BITS - 10'h001) begin
                  slots_reg <= slots_reg - 10'h001;
                end
              end
            end
            T_IPG: begin
              // After a collision the gap restarts while carrier is up.
              if (colflag_reg && crs_s_reg[g]) begin
                bits_reg <= 10'h000;
              end else if (tick) begin
                bits_reg <= bits_reg + 10'h001;
                if (bits_reg == `IPG_BITS - 10'h001) begin
                  ts_reg <= T_IDLE;
                end
              end
            end
            default: ts_reg <= T_IDLE;
          endcase
        end
      end
    end
  endgenerate
endmodule

// *** verification/switch_lookup_chk.sv ***
// Purpose: Port checks of the lookup and MAC engine.
// Assumes: CE held high.
// Notes: MAC timing is watched on port 0 only.
`timescale 1ns/1ps
module switch_lookup_chk #(parameter TBL_DEPTH = 16) (
  input wire CORE_CLK,
  input wire RESET_N,
  input wire RX_VALID,
  input wire RX_READY,
  input wire [1:0] RX_PORT,
  input wire [10:0] RX_LEN,
  input wire RX_ERR,
  input wire RX_PAUSE,
  input wire [15:0] RX_PAUSE_TIME,
  input wire FWD_VALID,
  input wire [1:0] FWD_PORT,
  input wire [2:0] FWD_MASK,
  input wire [2:0] SPEED100,
  input wire [2:0] TX_REQ,
  input wire [2:0] TX_FC,
  input wire [2:0] TX_END,
  input wire [2:0] MII_TRANSMIT_ENABLE,
  input wire [2:0] TX_DONE,
  input wire [2:0] PAUSED
);
  localparam int LAT = TBL_DEPTH + 2;
  localparam int LAT1 = TBL_DEPTH + 3;
  logic [10:0] gap_reg;
  // Gap since the last transmit enable; collision gaps are not exercised here.
  always @(posedge CORE_CLK or negedge RESET_N)
    if (!RESET_N) gap_reg <= 11'h7FF;
    else if (MII_TRANSMIT_ENABLE[0]) gap_reg <= 11'h000;
    else if (gap_reg != 11'h7FF) gap_reg <= gap_reg + 11'h001;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  sequence take;
    RX_VALID && RX_READY;
  endsequence
  chk_fwd_latency: assert property (take |-> ##LAT FWD_VALID)
    else $error("forward result missing");
  chk_err_drop: assert property (take and RX_ERR |-> ##LAT FWD_MASK == 3'h0)
    else $error("errored frame forwarded");
  chk_pause_drop: assert property (take and RX_PAUSE |-> ##LAT FWD_MASK == 3'h0)
    else $error("pause frame forwarded");
  chk_short_drop: assert property (take and RX_LEN < 11'h040 |-> ##LAT FWD_MASK == 3'h0)
    else $error("short frame forwarded");
  chk_no_local: assert property (FWD_VALID |-> !FWD_MASK[FWD_PORT])
    else $error("frame sent back to ingress");
  chk_pause_load: assert property (take and RX_PAUSE && !RX_ERR && RX_PORT == 2'h0 && RX_LEN >= 11'h040
    && RX_PAUSE_TIME != 16'h0000 |-> ##[1:LAT1] PAUSED[0])
    else $error("pause not applied");
  chk_tx_start: assert property ($rose(MII_TRANSMIT_ENABLE[0]) |->
    $past(TX_REQ[0]) && (!$past(PAUSED[0]) || $past(TX_FC[0])))
    else $error("illegal transmit start");
  chk_tx_end: assert property (MII_TRANSMIT_ENABLE[0] && TX_END[0] |=> !MII_TRANSMIT_ENABLE[0] && TX_DONE[0])
    else $error("transmit end not handled");
  chk_ipg_gap: assert property ($rose(MII_TRANSMIT_ENABLE[0]) |->
    gap_reg >= (SPEED100[0] ? 11'h0C0 : 11'h780))
    else $error("gap too short");
endmodule
bind switch_lookup_mac_engine switch_lookup_chk #(.TBL_DEPTH(TBL_DEPTH)) u_switch_lookup_chk (.*);

// *** verification/link_partner.sv ***
// Purpose: Link partner station on port 0.
// Assumes: Medium shows carrier while the MAC sends.
// Notes: Never collides, so retries stay unexercised.
`timescale 1ns/1ps
module link_partner (
  input wire clk,
  input wire tx_en,
  output logic crs
);
  always @(posedge clk) crs <= tx_en;
endmodule

// *** verification/switch_lookup_mac_engine_bench.sv ***
// Purpose: Self-checking bench of the lookup and MAC engine.
// Assumes: Short table and age tick keep the run brief.
// Notes: Many side inputs stay constant; their logic goes untested.
`timescale 1ns/1ps
module switch_lookup_mac_engine_bench;
  logic CORE_CLK=0, RESET_N=0, CE=1, AWVALID=0, WVALID=0, BREADY=0, ARVALID=0, RREADY=0, RX_VALID=0;
  logic RX_ERR=0, RX_TAGGED=0, RX_PAUSE=0, RX_STATIC_HIT=0, RX_IGMP=0, BUF_RELEASE=0, RXQ_FULL=0;
  logic [7:0] AWADDR=0, ARADDR=0;
  logic [31:0] WDATA=0, d;
  logic [3:0] WSTRB=4'hF;
  logic [1:0] RX_PORT=0, r;
  logic [47:0] RX_SA=0, RX_DA=0;
  logic [10:0] RX_LEN=0;
  logic [15:0] RX_PAUSE_TIME=16'h0001;
  logic [4:0] BUF_RELEASE_CNT=0;
  logic [2:0] RX_VLAN_MASK=3'h7, RX_STATIC_MASK=0, DEST_BUSY=0, SPEED100=3'h7, FULL_DUPLEX=3'h7;
  logic [2:0] TX_REQ=0, TX_FC=0, TX_END=0, MII_COL=0;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, RX_READY, FWD_VALID, crs;
  wire [1:0] BRESP, RRESP, FWD_PORT;
  wire [31:0] RDATA;
  wire [2:0] FWD_MASK, PAUSE_ON_FRAME, PAUSE_OFF_FRAME, MII_TRANSMIT_ENABLE, TX_DONE, TX_ABORT, PAUSED;
  wire [2:0] MII_CARRIER_SENSE = {2'h0, crs};
  int num_errors = 0, checked = 0, n;
  always #2.5 CORE_CLK = ~CORE_CLK;
  switch_lookup_mac_engine #(.TBL_DEPTH(16), .TBL_AW(4), .AGE_TICK_CYCLES(10)) u_switch_lookup_mac_engine (.*);
  link_partner u_link_partner (.clk(CORE_CLK), .tx_en(MII_TRANSMIT_ENABLE[0]), .crs(crs));
  task final_report;
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task stall(input int i);
    if (i > 3000) begin
      num_errors++;
      $display("Error %0t: wait ran out", $time);
      final_report;
    end
  endtask
  task rd(input logic [7:0] a);
    @(posedge CORE_CLK);
    ARADDR <= a; ARVALID <= 1; RREADY <= 1;
    for (int i = 0; 1; i++) begin
      @(posedge CORE_CLK);
      stall(i);
      if (ARREADY) ARVALID <= 0;
      if (RVALID) break;
    end
    d = RDATA; r = RRESP; RREADY <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CORE_CLK);
    AWADDR <= a; WDATA <= v; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
    for (int i = 0; 1; i++) begin
      @(posedge CORE_CLK);
      stall(i);
      if (AWREADY) AWVALID <= 0;
      if (WREADY) WVALID <= 0;
      if (BVALID) break;
    end
    BREADY <= 0;
  endtask
  task fr(input logic [1:0] p, input logic [47:0] sa, da, input logic [10:0] len, input logic [2:0] f, exp);
    @(posedge CORE_CLK);
    RX_PORT <= p; RX_SA <= sa; RX_DA <= da; RX_LEN <= len; {RX_ERR, RX_TAGGED, RX_PAUSE} <= f; RX_VALID <= 1;
    for (int i = 0; !RX_READY || i == 0; i++) begin @(posedge CORE_CLK); stall(i); end
    RX_VALID <= 0;
    for (int i = 0; !FWD_VALID; i++) begin @(posedge CORE_CLK); stall(i); end
    chk(FWD_MASK, exp);
  endtask
  task txend(input logic [2:0] q);
    @(posedge CORE_CLK) TX_END <= 3'h1;
    @(posedge CORE_CLK) TX_END <= 3'h0;
    TX_REQ <= q;
    @(posedge CORE_CLK) chk(TX_DONE, 3'h1);
  endtask
  task quiet;
    for (n = 0; !MII_TRANSMIT_ENABLE[0]; n++) begin @(posedge CORE_CLK); stall(n); end
  endtask
  initial begin
    repeat (8) @(posedge CORE_CLK);
    RESET_N <= 1;
    repeat (3) @(posedge CORE_CLK);
    rd(8'h0C); chk(d, 32'h4);
    rd(8'h10); chk(d, 32'h0);
    rd(8'h24); chk(d, 32'h0001FF07);
    rd(8'h20); chk(d, 32'h01000000);
    rd(8'h3C); chk(d, 0); chk(r, 2'h2);
    RXQ_FULL <= 1; repeat (2) @(posedge CORE_CLK); chk(PAUSE_ON_FRAME, 3'h7);
    RXQ_FULL <= 0; repeat (2) @(posedge CORE_CLK); chk(PAUSE_OFF_FRAME, 3'h7);
    wr(8'h0C, 32'h1); rd(8'h0C); chk(d, 32'h1);
    fr(0, 48'hA1, 48'hE4, 64, 0, 3'h6);
    fr(1, 48'hB2, 48'hA1, 64, 0, 3'h1);
    rd(8'h20); chk(d[10:0], 2);
    fr(0, 48'hA1, 48'hA1, 64, 0, 0);
    fr(2, 48'hA1, 48'hE4, 64, 0, 3'h3);
    fr(1, 48'hB2, 48'hA1, 64, 0, 3'h4);
    fr(0, 48'hC3, 48'hE4, 64, 3'h4, 0);
    rd(8'h20); chk(d[10:0], 2);
    fr(1, 48'hB2, 48'hE4, 63, 0, 0);
    fr(1, 48'hB2, 48'hE4, 1518, 0, 3'h5);
    fr(1, 48'hB2, 48'hE4, 1519, 0, 0);
    fr(1, 48'hB2, 48'hE4, 1522, 3'h2, 3'h5);
    wr(8'h10, 32'h28); rd(8'h10); chk(d, 32'h28);
    fr(1, 48'hB2, 48'hE4, 1916, 0, 3'h5);
    fr(0, 48'hA1, 48'hE4, 64, 3'h1, 0);
    @(posedge CORE_CLK); chk(PAUSED, 3'h1);
    TX_REQ <= 3'h1;
    quiet; chk(n > 1000, 1);
    txend(3'h1);
    quiet; chk(n >= 192, 1);
    txend(3'h0);
    wr(8'h0C, 32'h4);
    repeat (3000) @(posedge CORE_CLK);
    rd(8'h20); chk(d[10:0], 0);
    for (int k = 0; k < 17; k++) fr(1, 48'h100 + k, 48'hE4, 64, 0, 3'h5);
    rd(8'h20); chk(d[10:0], 16);
    fr(0, 48'hE4, 48'h110, 64, 0, 3'h2);
    final_report;
  end
endmodule
